// [include/iuvf_pkg.sv]
// Constants, state encoding and register image of the input undervoltage
// fault and start-up configuration block.
// Assumes a 40 MHz system clock and command codes delivered already decoded.
package iuvf_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned MS_CYC    = CLK_HZ / 1000;
  localparam int unsigned RETRY_MS  = 70;
  localparam int unsigned RETRY_CYC = RETRY_MS * MS_CYC;
  localparam int unsigned TON_MAX_MS = 5000;
  localparam int unsigned FRAC      = 16;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_CLEAR  = 8'h03;
  localparam logic [7:0] CMD_UV_LIM = 8'h59;
  localparam logic [7:0] CMD_UV_RSP = 8'h5a;
  localparam logic [7:0] CMD_PG_ON  = 8'h5e;
  localparam logic [7:0] CMD_TON    = 8'h60;
  localparam logic [7:0] CMD_STATUS = 8'h78;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned RSP_BEH_HI = 7;
  localparam int unsigned RSP_BEH_LO = 6;
  localparam int unsigned RSP_RTY_HI = 5;
  localparam int unsigned RSP_RTY_LO = 3;
  localparam logic [1:0]  BEH_DISABLE = 2'h2;
  localparam logic [2:0]  RTY_FOREVER = 3'h7;
  localparam int unsigned STS_OFF    = 6;
  localparam int unsigned STS_UV     = 3;
  localparam logic [7:0]  RSP_RST    = 8'h80;
  localparam logic [15:0] TON_RST    = 16'hca80;
  localparam logic [19:0] PG_NUM     = 20'h00009;
  localparam logic [19:0] PG_DEN     = 20'h0000a;
  // Undervoltage limits chosen by the strap inputs: 4.25, 6, 8 and 10 V
  localparam logic [3:0][15:0] UV_STRAP = {16'hf028, 16'hf020, 16'hf018, 16'hf011};

  typedef enum logic [2:0] {
    ST_LOAD  = 3'h0,
    ST_OFF   = 3'h1,
    ST_DELAY = 3'h3,
    ST_ON    = 3'h2,
    ST_FAULT = 3'h6,
    ST_RETRY = 3'h7
  } iuvf_state_t;

  typedef struct packed {
    iuvf_state_t st;
    logic [31:0] cnt;
    logic [31:0] ms;
    logic [15:0] uv_thr;
    logic [7:0]  uv_rsp;
    logic [15:0] pg_thr;
    logic [15:0] ton;
    logic        uv_flag;
    logic        alert_oe_n;
    logic        out_en;
    logic        pg;
    logic [15:0] rdata;
  } iuvf_regs_t;

  localparam iuvf_regs_t REGS_RST = '{
    st: ST_LOAD, cnt: 32'h0, ms: 32'h0, uv_thr: 16'h0, uv_rsp: RSP_RST,
    pg_thr: 16'h0, ton: TON_RST, uv_flag: 1'b0, alert_oe_n: 1'b1,
    out_en: 1'b0, pg: 1'b0, rdata: 16'h0};

endpackage : iuvf_pkg

// [include/iuvf_lin_if.sv]
// Carrier between a Linear-11 word and its fixed-point value.
// Assumes the converter is purely combinational.
`timescale 1ns/1ps
`default_nettype none
interface iuvf_lin_if;
  logic        [15:0] word;
  logic signed [47:0] fix;
  modport conv (input word, output fix);
  modport user (output word, input fix);
endinterface : iuvf_lin_if
`default_nettype wire

// [src/iuvf_lin11_conv.sv]
// Linear-11 to signed fixed point with FRAC fractional bits.
// Assumes exponent in bits 15:11 and mantissa in bits 10:0, both signed.
`timescale 1ns/1ps
`default_nettype none
module iuvf_lin11_conv (
  iuvf_lin_if.conv p
);

  logic signed [47:0] mant;
  logic        [4:0]  shift;

  // Exponent plus 16 is the exponent with its sign bit flipped
  assign mant  = {{37{p.word[10]}}, p.word[10:0]};
  assign shift = {~p.word[15], p.word[14:11]};
  assign p.fix = mant <<< shift;

endmodule : iuvf_lin11_conv
`default_nettype wire

// [src/iuvf_top.sv]
// Input undervoltage fault, response, power-good and turn-on delay logic.
// Assumes commands arrive decoded from the management link as one-cycle
// strobes and that measurements are synchronous to clk_i.
//
// Behaviour
// - The undervoltage threshold is a 16-bit read/write Linear-11 word.
// - After reset the threshold is loaded from the strap-selected setting.
// - The undervoltage response is a read/write byte that resets to 80h.
// - Behaviour code 10 in bits 7:6 disables the output on a fault and then follows the retry field.
// - A fault drives the alert line low and sets a flag that only clear-faults removes.
// - Retry code 000 keeps the output off until the fault flag is cleared.
// - Retry code 111 restarts without limit after every fault until enable drops.
// - Restarts are spaced by a fixed 70 ms and bits 2:0 of the response do nothing.
// - Power-good rises above its threshold and falls only below the output undervoltage limit.
// - The power-good threshold is an unsigned 16-bit word that resets to 0.9 of the strapped setpoint.
// - After enable the ramp starts once the programmed delay in milliseconds has passed.
// - The turn-on delay word resets to CA80h, which is 5 ms.
`timescale 1ns/1ps
`default_nettype none
module iuvf_top #(
  parameter int unsigned CYC_PER_MS = iuvf_pkg::MS_CYC,
  parameter int unsigned RETRY_CYC  = iuvf_pkg::RETRY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  pmb_cmd_i,
  input  wire logic        pmb_wr_i,
  input  wire logic        pmb_rd_i,
  input  wire logic [15:0] pmb_wdata_i,
  output logic      [15:0] pmb_rdata_o,
  input  wire logic        enable_i,
  input  wire logic [1:0]  strap_sel_i,
  input  wire logic [15:0] vout_strap_i,
  input  wire logic [15:0] vin_meas_i,
  input  wire logic [15:0] vout_meas_i,
  input  wire logic [15:0] vout_uv_limit_i,
  input  wire logic        alert_output_line_i,
  output logic             alert_output_line_o,
  output logic             alert_output_line_oe_n_o,
  output logic             output_enable_o,
  output logic             power_good_o
);

  // ****************************************
  // Linear-11 conversions
  // ****************************************
  iuvf_lin_if thr_if ();
  iuvf_lin_if vin_if ();
  iuvf_lin_if ton_if ();

  iuvf_pkg::iuvf_regs_t r;
  iuvf_pkg::iuvf_regs_t next_r;

  assign thr_if.word = r.uv_thr;
  assign vin_if.word = vin_meas_i;
  assign ton_if.word = r.ton;

  iuvf_lin11_conv u_thr (.p(thr_if));
  iuvf_lin11_conv u_vin (.p(vin_if));
  iuvf_lin11_conv u_ton (.p(ton_if));

  logic        [31:0] ton_ms;
  logic               running;
  logic               uv_det;
  logic               clear_cmd;
  logic        [19:0] pg_scaled;
  logic        [1:0]  beh;
  logic        [2:0]  rty;

  // Delay in whole milliseconds, negative reads as zero, capped at 5 s
  always_comb begin
    if (ton_if.fix[47]) begin
      ton_ms = 32'h0;
    end else if (ton_if.fix[47:iuvf_pkg::FRAC] > 32'(iuvf_pkg::TON_MAX_MS)) begin
      ton_ms = 32'(iuvf_pkg::TON_MAX_MS);
    end else begin
      ton_ms = ton_if.fix[47:iuvf_pkg::FRAC];
    end
  end

  assign running   = (r.st == iuvf_pkg::ST_DELAY) || (r.st == iuvf_pkg::ST_ON);
  assign uv_det    = running && (vin_if.fix < thr_if.fix);
  assign clear_cmd = pmb_wr_i && (pmb_cmd_i == iuvf_pkg::CMD_CLEAR);
  assign pg_scaled = ({4'h0, vout_strap_i} * iuvf_pkg::PG_NUM) / iuvf_pkg::PG_DEN;
  assign beh       = r.uv_rsp[iuvf_pkg::RSP_BEH_HI:iuvf_pkg::RSP_BEH_LO];
  assign rty       = r.uv_rsp[iuvf_pkg::RSP_RTY_HI:iuvf_pkg::RSP_RTY_LO];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    // Register writes
    if (pmb_wr_i) begin
      if (pmb_cmd_i == iuvf_pkg::CMD_UV_LIM) begin
        next_r.uv_thr = pmb_wdata_i;
      end else if (pmb_cmd_i == iuvf_pkg::CMD_UV_RSP) begin
        next_r.uv_rsp = pmb_wdata_i[7:0];
      end else if (pmb_cmd_i == iuvf_pkg::CMD_PG_ON) begin
        next_r.pg_thr = pmb_wdata_i;
      end else if (pmb_cmd_i == iuvf_pkg::CMD_TON) begin
        next_r.ton = pmb_wdata_i;
      end
    end
    // Register reads, unmapped codes answer zero
    if (pmb_rd_i) begin
      if (pmb_cmd_i == iuvf_pkg::CMD_UV_LIM) begin
        next_r.rdata = r.uv_thr;
      end else if (pmb_cmd_i == iuvf_pkg::CMD_UV_RSP) begin
        next_r.rdata = {8'h0, r.uv_rsp};
      end else if (pmb_cmd_i == iuvf_pkg::CMD_PG_ON) begin
        next_r.rdata = r.pg_thr;
      end else if (pmb_cmd_i == iuvf_pkg::CMD_TON) begin
        next_r.rdata = r.ton;
      end else if (pmb_cmd_i == iuvf_pkg::CMD_STATUS) begin
        next_r.rdata = 16'h0;
        next_r.rdata[iuvf_pkg::STS_OFF] = ~r.out_en;
        next_r.rdata[iuvf_pkg::STS_UV]  = r.uv_flag;
      end else begin
        next_r.rdata = 16'h0;
      end
    end
    // Sticky fault flag, a new fault wins over clear-faults
    next_r.uv_flag    = uv_det || (r.uv_flag && !clear_cmd);
    next_r.alert_oe_n = ~next_r.uv_flag;
    // Power-good hysteresis between the two thresholds
    if (vout_meas_i > r.pg_thr) begin
      next_r.pg = 1'b1;
    end else if (vout_meas_i < vout_uv_limit_i) begin
      next_r.pg = 1'b0;
    end
    // Sequencer
    case (r.st)
      iuvf_pkg::ST_LOAD: begin
        next_r.uv_thr = iuvf_pkg::UV_STRAP[strap_sel_i];
        next_r.pg_thr = pg_scaled[15:0];
        next_r.st     = iuvf_pkg::ST_OFF;
      end
      iuvf_pkg::ST_OFF: begin
        if (enable_i) begin
          next_r.st  = iuvf_pkg::ST_DELAY;
          next_r.cnt = 32'h0;
          next_r.ms  = 32'h0;
        end
      end
      iuvf_pkg::ST_DELAY, iuvf_pkg::ST_ON: begin
        if (uv_det && beh == iuvf_pkg::BEH_DISABLE) begin
          next_r.out_en = 1'b0;
          next_r.cnt    = 32'h0;
          if (rty == iuvf_pkg::RTY_FOREVER) begin
            next_r.st = iuvf_pkg::ST_RETRY;
          end else begin
            next_r.st = iuvf_pkg::ST_FAULT;
          end
        end else if (!enable_i) begin
          next_r.out_en = 1'b0;
          next_r.st     = iuvf_pkg::ST_OFF;
        end else if (r.st == iuvf_pkg::ST_DELAY) begin
          if (r.ms >= ton_ms) begin
            next_r.out_en = 1'b1;
            next_r.st     = iuvf_pkg::ST_ON;
          end else if (r.cnt == CYC_PER_MS - 1) begin
            next_r.cnt = 32'h0;
            next_r.ms  = r.ms + 32'h1;
          end else begin
            next_r.cnt = r.cnt + 32'h1;
          end
        end
      end
      iuvf_pkg::ST_FAULT: begin
        if (!r.uv_flag) begin
          next_r.st = iuvf_pkg::ST_OFF;
        end
      end
      iuvf_pkg::ST_RETRY: begin
        if (!enable_i) begin
          next_r.st = iuvf_pkg::ST_OFF;
        end else if (r.cnt == RETRY_CYC - 1) begin
          next_r.st  = iuvf_pkg::ST_DELAY;
          next_r.cnt = 32'h0;
          next_r.ms  = 32'h0;
        end else begin
          next_r.cnt = r.cnt + 32'h1;
        end
      end
      default: begin
        next_r.st = iuvf_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= iuvf_pkg::REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pmb_rdata_o              = r.rdata;
  assign alert_output_line_o      = 1'b0;
  assign alert_output_line_oe_n_o = r.alert_oe_n;
  assign output_enable_o          = r.out_en;
  assign power_good_o             = r.pg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  resp_reset_a: assert property ($past(rst_i) |-> r.uv_rsp == iuvf_pkg::RSP_RST)
    else $error("response byte not 80h after reset");
  delay_reset_a: assert property ($past(rst_i) |-> r.ton == iuvf_pkg::TON_RST && ton_ms == 32'h5)
    else $error("turn-on delay not 5 ms after reset");
  strap_load_a: assert property ($past(r.st) == iuvf_pkg::ST_LOAD && !$past(rst_i)
      |-> r.uv_thr == iuvf_pkg::UV_STRAP[$past(strap_sel_i)])
    else $error("threshold not taken from strap");
  fault_alert_a: assert property (uv_det |=> r.uv_flag && !alert_output_line_oe_n_o)
    else $error("fault did not set flag and alert");
  flag_hold_a: assert property (r.uv_flag && !clear_cmd |=> r.uv_flag && !alert_output_line_oe_n_o)
    else $error("fault flag dropped without clear");
  fault_off_a: assert property (uv_det && beh == iuvf_pkg::BEH_DISABLE |=> !output_enable_o [*2])
    else $error("output not disabled on fault");
  noretry_hold_a: assert property (r.st == iuvf_pkg::ST_FAULT && r.uv_flag |=> r.st == iuvf_pkg::ST_FAULT)
    else $error("restart before fault cleared");
  retry_gap_a: assert property ($past(r.st) == iuvf_pkg::ST_RETRY && r.st == iuvf_pkg::ST_DELAY
      |-> $past(r.cnt) == RETRY_CYC - 1)
    else $error("retry interval wrong");
  retry_path_a: assert property (uv_det && beh == iuvf_pkg::BEH_DISABLE && rty == iuvf_pkg::RTY_FOREVER
      |=> r.st == iuvf_pkg::ST_RETRY)
    else $error("continuous retry not entered");
  pg_rise_a: assert property ($rose(power_good_o) |-> $past(vout_meas_i) > $past(r.pg_thr))
    else $error("power-good rose below threshold");
  pg_fall_a: assert property ($fell(power_good_o) |-> $past(vout_meas_i) < $past(vout_uv_limit_i))
    else $error("power-good fell above undervoltage limit");
  ton_wait_a: assert property ($rose(output_enable_o)
      |-> $past(r.st) == iuvf_pkg::ST_DELAY && $past(r.ms) >= $past(ton_ms))
    else $error("ramp started before turn-on delay");

  start_c: cover property ($rose(output_enable_o));
  fault_c: cover property (r.st == iuvf_pkg::ST_FAULT ##1 r.st == iuvf_pkg::ST_OFF);
  retry_c: cover property (r.st == iuvf_pkg::ST_RETRY ##1 r.st == iuvf_pkg::ST_DELAY);
  pg_c:    cover property ($fell(power_good_o));

endmodule : iuvf_top
`default_nettype wire

// [test/iuvf_host_model.sv]
// Management-link host stand-in that issues decoded command strobes.
// Assumes read data appears on the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module iuvf_host_model (
  input  wire logic        clk_i,
  output logic      [7:0]  cmd_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [15:0] wdata_o,
  output logic             rvalid_o
);
  initial begin
    cmd_o   = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 16'h0000;
  end
  // Marks the cycle in which returned read data stands
  always @(posedge clk_i) begin
    rvalid_o <= rd_o;
  end
  task automatic write(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge clk_i);
    cmd_o   <= cmd;
    wdata_o <= data;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~data;
  endtask : write
  task automatic read(input logic [7:0] cmd);
    @(posedge clk_i);
    cmd_o <= cmd;
    rd_o  <= 1'b1;
    @(posedge clk_i);
    rd_o  <= 1'b0;
    cmd_o <= ~cmd;
  endtask : read
endmodule : iuvf_host_model
`default_nettype wire

// [test/iuvf_tb_top.sv]
// Self-checking bench of the undervoltage fault and start-up block.
// Assumes shortened counts: 4 cycles a millisecond, 20 cycles a retry.
`timescale 1ns/1ps
`default_nettype none
module iuvf_tb_top;
  localparam int unsigned CPM = 4;
  localparam int unsigned RTY = 20;
  logic        clk_i, rst_i, enable_i, wr, rd, rvalid, alert_o, alert_oe_n, out_en, pg;
  logic [1:0]  strap_sel_i;
  logic [7:0]  cmd;
  logic [15:0] vout_strap_i, vin_meas_i, vout_meas_i, vout_uv_limit_i, wdata, rdata, wv;
  logic [15:0] exp_q[$];
  logic [7:0]  cmds[4] = '{8'h59, 8'h5a, 8'h5e, 8'h60};
  logic [15:0] tons[3] = '{16'h0002, 16'hca80, 16'h0000};
  logic [15:0] vouts[4] = '{16'h0101, 16'h00c0, 16'h007f, 16'h00c0};
  int          n_errors, tests_run, n;
  int          ms[3] = '{2, 5, 0};
  wire         alert_line = alert_oe_n ? 1'b1 : alert_o;

  iuvf_host_model host_u (.clk_i(clk_i), .cmd_o(cmd), .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rvalid_o(rvalid));
  iuvf_top #(.CYC_PER_MS(CPM), .RETRY_CYC(RTY)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .pmb_cmd_i(cmd), .pmb_wr_i(wr), .pmb_rd_i(rd),
    .pmb_wdata_i(wdata), .pmb_rdata_o(rdata), .enable_i(enable_i), .strap_sel_i(strap_sel_i),
    .vout_strap_i(vout_strap_i), .vin_meas_i(vin_meas_i), .vout_meas_i(vout_meas_i),
    .vout_uv_limit_i(vout_uv_limit_i), .alert_output_line_i(alert_line),
    .alert_output_line_o(alert_o), .alert_output_line_oe_n_o(alert_oe_n),
    .output_enable_o(out_en), .power_good_o(pg));

  always #12.5 clk_i = ~clk_i;

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      n_errors++;
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
    exp_q.push_back(e);
    host_u.read(c);
  endtask : rd_chk
  task automatic wait_oe(input logic v);
    n = 0;
    while (out_en !== v) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 400) begin
        $display("wrong value at %0t: output enable wait ran out", $time);
        n_errors++;
        stop_test();
      end
    end
  endtask : wait_oe
  task automatic fault(input logic [15:0] after);
    @(posedge clk_i);
    vin_meas_i <= 16'hf010;
    #1;
    wait_oe(1'b0);
    @(posedge clk_i);
    vin_meas_i <= after;
  endtask : fault

  // ****************************************
  // Read-data monitor
  // ****************************************
  always @(posedge clk_i) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(rdata, 16'hxxxx, "unexpected read");
      else check(rdata, exp_q.pop_front(), "read data");
    end
  end

  initial begin
    void'($urandom(53));
    clk_i = 1'b0;
    rst_i = 1'b1;
    enable_i = 1'b0;
    strap_sel_i = 2'($urandom);
    vout_strap_i = 16'($urandom);
    vin_meas_i = 16'hf030;
    vout_meas_i = 16'h0000;
    vout_uv_limit_i = 16'h0080;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(iuvf_pkg::CMD_UV_LIM, iuvf_pkg::UV_STRAP[strap_sel_i]);
    rd_chk(iuvf_pkg::CMD_UV_RSP, 16'h0080);
    rd_chk(iuvf_pkg::CMD_PG_ON, 16'((20'(vout_strap_i) * 20'h9) / 20'ha));
    rd_chk(iuvf_pkg::CMD_TON, 16'hca80);
    rd_chk(8'h42, 16'h0000);
    $display("reset values test done");
    for (int i = 0; i < 4; i++) begin
      wv = 16'($urandom);
      host_u.write(cmds[i], wv);
      rd_chk(cmds[i], (i == 1) ? {8'h00, wv[7:0]} : wv);
    end
    host_u.write(iuvf_pkg::CMD_UV_LIM, 16'hf020);
    host_u.write(iuvf_pkg::CMD_UV_RSP, 16'h0080);
    host_u.write(iuvf_pkg::CMD_PG_ON, 16'h0100);
    $display("register access test done");
    for (int i = 0; i < 3; i++) begin
      host_u.write(iuvf_pkg::CMD_TON, tons[i]);
      @(posedge clk_i);
      enable_i <= 1'b1;
      #1;
      wait_oe(1'b1);
      check(16'(n >= ms[i] * CPM + 1 && n <= ms[i] * CPM + 4), 16'h1, "turn-on delay");
      @(posedge clk_i);
      enable_i <= 1'b0;
      #1;
      wait_oe(1'b0);
    end
    $display("turn-on delay test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      vout_meas_i <= vouts[i];
      repeat (2) @(posedge clk_i);
      #1;
      check({15'h0, pg}, {15'h0, i < 2}, "power good");
    end
    $display("power good test done");
    @(posedge clk_i);
    enable_i <= 1'b1;
    #1;
    wait_oe(1'b1);
    fault(16'hf030);
    check(16'(n <= 2), 16'h1, "fault shutdown latency");
    check({15'h0, alert_line}, 16'h0, "alert low on fault");
    repeat (3 * RTY) @(posedge clk_i);
    #1;
    check({15'h0, out_en}, 16'h0, "output held off");
    rd_chk(iuvf_pkg::CMD_STATUS, 16'h0048);
    host_u.write(iuvf_pkg::CMD_STATUS, 16'h0000);
    host_u.write(iuvf_pkg::CMD_CLEAR, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1;
    check({15'h0, alert_line}, 16'h1, "alert released");
    wait_oe(1'b1);
    rd_chk(iuvf_pkg::CMD_STATUS, 16'h0000);
    $display("shutdown without retry test done");
    for (int i = 0; i < 2; i++) begin
      host_u.write(iuvf_pkg::CMD_UV_RSP, i ? 16'h00bf : 16'h00b8);
      fault(16'hf030);
      #1;
      wait_oe(1'b1);
      check(16'(n >= RTY - 2 && n <= RTY + 8), 16'h1, "retry interval");
    end
    fault(16'hf030);
    enable_i <= 1'b0;
    repeat (2 * RTY + 10) @(posedge clk_i);
    #1;
    check({15'h0, out_en}, 16'h0, "retry stops when disabled");
    check({15'h0, alert_line}, 16'h0, "flag kept until clear");
    @(posedge clk_i);
    enable_i <= 1'b1;
    #1;
    wait_oe(1'b1);
    check(16'(n <= 4), 16'h1, "restart from off");
    // Off command in mid-interval must end the retry at once
    fault(16'hf030);
    enable_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    enable_i <= 1'b1;
    #1;
    wait_oe(1'b1);
    check(16'(n <= 4), 16'h1, "retry left when disabled");
    host_u.write(iuvf_pkg::CMD_CLEAR, 16'h0000);
    // Behaviour code 01 flags the fault and leaves the output on
    host_u.write(iuvf_pkg::CMD_UV_RSP, 16'h0040);
    @(posedge clk_i);
    vin_meas_i <= 16'hf010;
    repeat (3) @(posedge clk_i);
    #1;
    check({15'h0, out_en}, 16'h1, "output kept on");
    check({15'h0, alert_line}, 16'h0, "alert low on flag only fault");
    @(posedge clk_i);
    vin_meas_i <= 16'hf030;
    host_u.write(iuvf_pkg::CMD_CLEAR, 16'h0000);
    $display("retry test done");
    repeat (4) @(posedge clk_i);
    check(16'(exp_q.size()), 16'h0, "reads answered");
    stop_test();
  end
endmodule : iuvf_tb_top
`default_nettype wire
